// File: rtl/pvr_pkg.sv
package pvr_pkg;

   // register offsets, byte addresses within the block
   localparam logic [11:0] RAM_EVT_OFS = 12'h100;
   localparam logic [11:0] FLASH_EVT_OFS = 12'h104;
   localparam logic [11:0] PERIPH_EVT_OFS = 12'h108;
   localparam logic [11:0] RAM_PUB_OFS = 12'h180;
   localparam logic [11:0] FLASH_PUB_OFS = 12'h184;
   localparam logic [11:0] PERIPH_PUB_OFS = 12'h188;
   localparam logic [11:0] INTERRUPT_ENABLE_OFS = 12'h300;
   localparam logic [11:0] INTERRUPT_ENABLE_SET_OFS = 12'h304;
   localparam logic [11:0] INTERRUPT_ENABLE_CLR_OFS = 12'h308;

   // decoded address width and event count
   localparam int ADDR_W = 12;
   localparam int NUM_EVENTS = 3;

   // event slot indices, also interrupt enable bit positions
   localparam int RAM_IDX = 0;
   localparam int FLASH_IDX = 1;
   localparam int PERIPH_IDX = 2;
   localparam logic [1:0] NO_SLOT = 2'h3;

   // field positions
   localparam int EVT_FLAG_BIT = 0;
   localparam int PUB_PUBLISH_CHANNEL_INDEX_LSB = 0;
   localparam int PUB_PUBLISH_CHANNEL_INDEX_W = 4;
   localparam int PUB_EN_BIT = 31;

   // values after reset
   localparam logic EVT_RESET = 1'b0;
   localparam logic PUB_EN_RESET = 1'b0;
   localparam logic [PUB_PUBLISH_CHANNEL_INDEX_W-1:0] PUB_PUBLISH_CHANNEL_INDEX_RESET = 4'h0;
   localparam logic [NUM_EVENTS-1:0] INTERRUPT_ENABLE_RESET = 3'h0;

   // default number of event channels
   localparam int NUM_CHANNELS_DEF = 16;

   // ahb transfer type with the data-carrying bit
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

endpackage : pvr_pkg

// File: rtl/pvr_event_slot.sv
`timescale 1ns/1ps
`default_nettype none

// one violation event: sticky flag plus its publish configuration
module pvr_event_slot
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic violation,
   input wire logic flagWrite,
   input wire logic flagData,
   input wire logic cfgWrite,
   input wire logic [31:0] cfgData,
   output logic flag,
   output logic publishEn,
   output logic [pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_W-1:0] channelIdx
);

   // a violation in the same cycle as a software write wins, so none is lost
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         flag <= pvr_pkg::EVT_RESET;
      else if (violation)
         flag <= 1'b1;
      else if (flagWrite)
         flag <= flagData;
   end

   // publish enable in the top bit, channel index in the low field
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         publishEn <= pvr_pkg::PUB_EN_RESET;
         channelIdx <= pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_RESET;
      end
      else if (cfgWrite)
      begin
         publishEn <= cfgData[pvr_pkg::PUB_EN_BIT];
         channelIdx <= cfgData[pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_LSB +: pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_W];
      end
   end

endmodule : pvr_event_slot

`default_nettype wire

// File: rtl/pvr_violation_event_regs.sv
// Operation
// - ram_violation_event flag reads 1 after a RAM access violation, else 0. Here a software write of 1 also sets it.
// - flash_violation_event flag sets on a flash access violation.
// - periph_violation_event flag sets on a peripheral access violation.
// - RAM publish config: channel index plus enable bit 31, reset zero.
// - Flash publish config: same layout, signals chosen channel when enabled.
// - Peripheral publish config: same layout, signals chosen channel when enabled.
// - interrupt_enable holds one enable bit per event, reset zero.
// - Writing 1 to interrupt_enable_set enables; reads show enable state.
// - Writing 1 to interrupt_enable_clear disables; reads show enable state.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pvr_violation_event_regs
#(
   parameter int NUM_CHANNELS = pvr_pkg::NUM_CHANNELS_DEF
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic ramAccessViolation,
   input wire logic flashAccessViolation,
   input wire logic periphAccessViolation,
   output logic [NUM_CHANNELS-1:0] eventChannelPulse,
   output logic irq
);

   localparam int CHW = pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_W;
   localparam int NE = pvr_pkg::NUM_EVENTS;

   // the channel index field cannot name more channels than it has codes
   if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << CHW))
   begin : gBadChannels
      $error("NUM_CHANNELS out of range for the channel index field");
   end

   // maps an address to an event slot of a bank of three, or NO_SLOT
   function automatic logic [1:0] slotOf
   (
      input logic [pvr_pkg::ADDR_W-1:0] addr,
      input logic [pvr_pkg::ADDR_W-1:0] base
   );
      logic [1:0] slot;
      slot = pvr_pkg::NO_SLOT;
      if (addr == base)
         slot = 2'(pvr_pkg::RAM_IDX);
      else if (addr == base + 12'h004)
         slot = 2'(pvr_pkg::FLASH_IDX);
      else if (addr == base + 12'h008)
         slot = 2'(pvr_pkg::PERIPH_IDX);
      return slot;
   endfunction : slotOf

   logic [NE-1:0] violation;
   logic [NE-1:0] flag;
   logic [NE-1:0] publishEn;
   logic [CHW-1:0] channelIdx [NE];
   logic [NE-1:0] interruptEnable;
   logic [NE-1:0] flagWrite;
   logic [NE-1:0] cfgWrite;
   logic dataValid;
   logic dataWrite;
   logic [pvr_pkg::ADDR_W-1:0] dataAddr;
   logic addrAccept;
   logic busWrite;
   logic wrDirect;
   logic wrSet;
   logic wrClear;
   logic [1:0] wrEvtSlot;
   logic [1:0] wrPubSlot;
   logic [1:0] rdEvtSlot;
   logic [1:0] rdPubSlot;
   logic [31:0] next_hrdata;
   logic [NUM_CHANNELS-1:0] next_pulse;
   logic [NE-1:0] wrBits;

   // detection logic shares ref_clk, so these need no synchroniser
   assign violation[pvr_pkg::RAM_IDX] = ramAccessViolation;
   assign violation[pvr_pkg::FLASH_IDX] = flashAccessViolation;
   assign violation[pvr_pkg::PERIPH_IDX] = periphAccessViolation;

   // address phase is taken when selected, ready and nonseq or seq
   assign addrAccept = hsel && hready && htrans[pvr_pkg::HTRANS_ACTIVE_BIT];

   // address phase register; only word transfers are expected, hsize unused
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dataValid <= 1'b0;
         dataWrite <= 1'b0;
         dataAddr <= '0;
      end
      else if (hready)
      begin
         dataValid <= addrAccept;
         dataWrite <= hwrite;
         dataAddr <= haddr[pvr_pkg::ADDR_W-1:0];
      end
   end

   // zero wait states, always okay: outputs come from flops out of reset
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hreadyout <= 1'b0;
         hresp <= pvr_pkg::HRESP_OKAY;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= pvr_pkg::HRESP_OKAY;
      end
   end

   // write decode in the data phase, when hwdata is valid
   assign busWrite = dataValid && dataWrite;
   assign wrDirect = busWrite && (dataAddr == pvr_pkg::INTERRUPT_ENABLE_OFS);
   assign wrSet = busWrite && (dataAddr == pvr_pkg::INTERRUPT_ENABLE_SET_OFS);
   assign wrClear = busWrite && (dataAddr == pvr_pkg::INTERRUPT_ENABLE_CLR_OFS);
   assign wrEvtSlot = slotOf(dataAddr, pvr_pkg::RAM_EVT_OFS);
   assign wrPubSlot = slotOf(dataAddr, pvr_pkg::RAM_PUB_OFS);
   assign wrBits = hwdata[NE-1:0];

   // per-slot write strobes
   always_comb
   begin
      flagWrite = '0;
      cfgWrite = '0;
      for (int i = 0; i < NE; i++)
      begin
         flagWrite[i] = busWrite && (wrEvtSlot == 2'(i));
         cfgWrite[i] = busWrite && (wrPubSlot == 2'(i));
      end
   end

   // one slot per event: flag and publish configuration
   for (genvar g = 0; g < NE; g++)
   begin : gSlot
      pvr_event_slot uSlot
      (
         .ref_clk(ref_clk),
         .resetn(resetn),
         .violation(violation[g]),
         .flagWrite(flagWrite[g]),
         .flagData(hwdata[pvr_pkg::EVT_FLAG_BIT]),
         .cfgWrite(cfgWrite[g]),
         .cfgData(hwdata),
         .flag(flag[g]),
         .publishEn(publishEn[g]),
         .channelIdx(channelIdx[g])
      );
   end

   // one enable set behind three views; zeros via set or clear change nothing
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         interruptEnable <= pvr_pkg::INTERRUPT_ENABLE_RESET;
      else if (wrDirect)
         interruptEnable <= wrBits;
      else if (wrSet)
         interruptEnable <= interruptEnable | wrBits;
      else if (wrClear)
         interruptEnable <= interruptEnable & ~wrBits;
   end

   // read decode in the address phase so hrdata is ready for the data phase
   assign rdEvtSlot = slotOf(haddr[pvr_pkg::ADDR_W-1:0], pvr_pkg::RAM_EVT_OFS);
   assign rdPubSlot = slotOf(haddr[pvr_pkg::ADDR_W-1:0], pvr_pkg::RAM_PUB_OFS);

   // unmapped and reserved bits read zero
   always_comb
   begin
      next_hrdata = '0;
      if (rdEvtSlot != pvr_pkg::NO_SLOT)
         next_hrdata[pvr_pkg::EVT_FLAG_BIT] = flag[rdEvtSlot];
      else if (rdPubSlot != pvr_pkg::NO_SLOT)
      begin
         next_hrdata[pvr_pkg::PUB_EN_BIT] = publishEn[rdPubSlot];
         next_hrdata[pvr_pkg::PUB_PUBLISH_CHANNEL_INDEX_LSB +: CHW] = channelIdx[rdPubSlot];
      end
      else if (haddr[pvr_pkg::ADDR_W-1:0] == pvr_pkg::INTERRUPT_ENABLE_OFS
         || haddr[pvr_pkg::ADDR_W-1:0] == pvr_pkg::INTERRUPT_ENABLE_SET_OFS
         || haddr[pvr_pkg::ADDR_W-1:0] == pvr_pkg::INTERRUPT_ENABLE_CLR_OFS)
         next_hrdata[NE-1:0] = interruptEnable;
   end

   // read data held for the data phase; zero outside reads
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         hrdata <= '0;
      else if (hready)
         hrdata <= (addrAccept && !hwrite) ? next_hrdata : 32'h0000_0000;
   end

   // publish: each enabled event strobes its channel; shared channels merge
   always_comb
   begin
      next_pulse = '0;
      for (int i = 0; i < NE; i++)
      begin
         if (violation[i] && publishEn[i]
            && 32'(channelIdx[i]) < NUM_CHANNELS)
            next_pulse[channelIdx[i]] = 1'b1;
      end
   end

   // a one-cycle strobe per event; a channel index past the top is dropped
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         eventChannelPulse <= '0;
      else
         eventChannelPulse <= next_pulse;
   end

   // level interrupt, registered so it lags the flag by one cycle
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(flag & interruptEnable);
   end

   // every violation leaves its flag set on the next edge
   a_ram_flag_set: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      ramAccessViolation |=> flag[pvr_pkg::RAM_IDX])
      else $error("ram flag not set after violation");

   a_flash_flag_set: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      flashAccessViolation && flagWrite[pvr_pkg::FLASH_IDX]
         |=> flag[pvr_pkg::FLASH_IDX])
      else $error("flash flag lost against a software write");

   a_periph_flag_hold: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $rose(flag[pvr_pkg::PERIPH_IDX]) |-> $past(periphAccessViolation)
         || $past(flagWrite[pvr_pkg::PERIPH_IDX]))
      else $error("periph flag rose without cause");

   // no violation, no channel strobe
   a_pub_quiet: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (violation == '0) |=> (eventChannelPulse == '0))
      else $error("channel strobe without a violation");

   a_flash_publish: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      flashAccessViolation && publishEn[pvr_pkg::FLASH_IDX]
         && 32'(channelIdx[pvr_pkg::FLASH_IDX]) < NUM_CHANNELS
         |=> eventChannelPulse[$past(channelIdx[pvr_pkg::FLASH_IDX])])
      else $error("flash violation not published");

   a_periph_pub_gate: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      periphAccessViolation && !publishEn[pvr_pkg::PERIPH_IDX]
         && !ramAccessViolation && !flashAccessViolation
         |=> (eventChannelPulse == '0))
      else $error("disabled periph publish still strobed");

   // the direct view loads the whole enable set
   a_interrupt_enable_direct: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      wrDirect |=> interruptEnable == $past(wrBits))
      else $error("direct enable write not stored");

   a_interrupt_enable_set: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      wrSet |=> (interruptEnable & $past(wrBits)) == $past(wrBits))
      else $error("set view did not enable");

   a_interrupt_enable_clear: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      wrClear |=> (interruptEnable & $past(wrBits)) == '0)
      else $error("clear view did not disable");

   a_zero_keeps_bits: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      wrSet || wrClear
         |=> (interruptEnable & ~$past(wrBits))
            == ($past(interruptEnable) & ~$past(wrBits)))
      else $error("zero written via set or clear changed a bit");

   // irq follows flag and enable one cycle later, both ways
   a_irq_follows: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      ##1 irq == $past(|(flag & interruptEnable)))
      else $error("irq does not match flags and enables");

   a_flag_clear_zero: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      flagWrite[pvr_pkg::RAM_IDX] && !hwdata[pvr_pkg::EVT_FLAG_BIT]
         && !ramAccessViolation ##1 !ramAccessViolation[*2]
         |-> !flag[pvr_pkg::RAM_IDX])
      else $error("ram flag not cleared by writing zero");

   // zero wait states once out of reset; the first edge after release
   // still shows the reset value, so start from the second one
   a_bus_ready: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $past(resetn) |-> hreadyout && hresp == pvr_pkg::HRESP_OKAY)
      else $error("slave stalled or errored");

endmodule : pvr_violation_event_regs

`default_nettype wire

// File: tb/pvr_far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side: violation detectors plus the event channel network
module pvr_far_side_model
#(
   parameter int NUM_CHANNELS = 16
)
(
   input wire logic ref_clk,
   input wire logic [NUM_CHANNELS-1:0] eventChannelPulse,
   output logic ramAccessViolation,
   output logic flashAccessViolation,
   output logic periphAccessViolation,
   output logic [NUM_CHANNELS-1:0] seenChannels,
   output logic [7:0] pulseCycles
);
   initial
   begin
      {ramAccessViolation, flashAccessViolation, periphAccessViolation} = 3'h0;
      seenChannels = {NUM_CHANNELS{1'b0}};
      pulseCycles = 8'h00;
   end

   // one-cycle violation pulse; call right after a rising edge
   task fire(input logic [2:0] m);
      ramAccessViolation <= m[0];
      flashAccessViolation <= m[1];
      periphAccessViolation <= m[2];
      @(posedge ref_clk);
      {ramAccessViolation, flashAccessViolation, periphAccessViolation} <= 3'h0;
   endtask : fire

   // forget what was collected; only call while no pulse is expected
   task clear_seen();
      seenChannels <= {NUM_CHANNELS{1'b0}};
      pulseCycles <= 8'h00;
   endtask : clear_seen

   // collect every published pulse; merged pulses count as one cycle
   always @(posedge ref_clk)
   begin
      if (|eventChannelPulse)
      begin
         seenChannels <= seenChannels | eventChannelPulse;
         pulseCycles <= pulseCycles + 8'h01;
      end
   end
endmodule : pvr_far_side_model
`default_nettype wire

// File: tb/pvr_violation_event_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
   begin checks_done++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end

module pvr_violation_event_regs_test;
   logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic ramV, flashV, periphV;
   logic [15:0] chPulse, seen;
   logic [7:0] pulseCycles;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;

   pvr_violation_event_regs pvr_violation_event_regs_i (
      .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .ramAccessViolation(ramV),
      .flashAccessViolation(flashV), .periphAccessViolation(periphV),
      .eventChannelPulse(chPulse), .irq(irq));

   pvr_far_side_model #(.NUM_CHANNELS(16)) pvr_far_side_model_i (
      .ref_clk(ref_clk), .eventChannelPulse(chPulse),
      .ramAccessViolation(ramV), .flashAccessViolation(flashV),
      .periphAccessViolation(periphV), .seenChannels(seen),
      .pulseCycles(pulseCycles));

   // clock at 10 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // one bus transfer; the data phase follows the accepted address phase
   task ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= wr ? d : 32'h00000000;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK("response", 1'b0, hresp)
   endtask : ahb_xfer

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      ahb_xfer(1'b0, a, 32'h00000000);
      `CHK("read data", exp, rd)
   endtask : rd_chk

   task wait_cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wait_cycles

   // every register and an unmapped place read zero after reset
   task test_reset_values();
      logic [11:0] ofs [10];
      ofs = '{12'h100, 12'h104, 12'h108, 12'h180, 12'h184, 12'h188,
              12'h300, 12'h304, 12'h308, 12'h400};
      foreach (ofs[i]) rd_chk(ofs[i], 32'h00000000);
      ahb_xfer(1'b1, 12'h400, 32'hffffffff);
      rd_chk(12'h400, 32'h00000000);
   endtask : test_reset_values

   // each violation sets only its own flag; writing 0 clears it
   task test_event_flags();
      logic [11:0] ofs [3];
      ofs = '{12'h100, 12'h104, 12'h108};
      for (int i = 0; i < 3; i++)
      begin
         pvr_far_side_model_i.fire(3'h1 << i);
         wait_cycles(1);
         foreach (ofs[j]) rd_chk(ofs[j], {31'h0, i == j});
         `CHK("irq while disabled", 1'b0, irq)
         ahb_xfer(1'b1, ofs[i], 32'h00000000);
         wait_cycles(1);
         rd_chk(ofs[i], 32'h00000000);
      end
   endtask : test_event_flags

   // two publishers share a cycle, one disabled stays silent
   task test_publish();
      ahb_xfer(1'b1, 12'h180, 32'h80000005);
      ahb_xfer(1'b1, 12'h184, 32'h8000000f);
      ahb_xfer(1'b1, 12'h188, 32'h00000003);
      wait_cycles(1);
      rd_chk(12'h180, 32'h80000005);
      rd_chk(12'h184, 32'h8000000f);
      rd_chk(12'h188, 32'h00000003);
      pvr_far_side_model_i.clear_seen();
      pvr_far_side_model_i.fire(3'h7);
      wait_cycles(3);
      `CHK("published channels", 16'h8020, seen)
      `CHK("pulse cycles", 8'h01, pulseCycles)
      ahb_xfer(1'b1, 12'h180, 32'h00000005);
      ahb_xfer(1'b1, 12'h188, 32'h80000003);
      pvr_far_side_model_i.clear_seen();
      pvr_far_side_model_i.fire(3'h5);
      wait_cycles(3);
      `CHK("published channels", 16'h0008, seen)
      for (int i = 0; i < 3; i++)
         ahb_xfer(1'b1, 12'h100 + 12'(4 * i), 32'h00000000);
   endtask : test_publish

   // a violation in the data phase of a clearing write leaves its flag set
   task test_set_wins();
      fork
         ahb_xfer(1'b1, 12'h104, 32'h00000000);
         begin
            @(posedge ref_clk);
            pvr_far_side_model_i.fire(3'h2);
         end
      join
      wait_cycles(1);
      rd_chk(12'h104, 32'h00000001);
      ahb_xfer(1'b1, 12'h104, 32'h00000000);
      rd_chk(12'h104, 32'h00000000);
   endtask : test_set_wins

   // three views of one enable set, with zero writes as no-ops
   task test_enable_views();
      ahb_xfer(1'b1, 12'h300, 32'h00000005);
      wait_cycles(1);
      for (int i = 0; i < 3; i++)
         rd_chk(12'h300 + 12'(4 * i), 32'h00000005);
      ahb_xfer(1'b1, 12'h304, 32'h00000002);
      ahb_xfer(1'b1, 12'h304, 32'h00000000);
      wait_cycles(1);
      rd_chk(12'h304, 32'h00000007);
      ahb_xfer(1'b1, 12'h308, 32'h00000001);
      ahb_xfer(1'b1, 12'h308, 32'h00000000);
      wait_cycles(1);
      rd_chk(12'h308, 32'h00000006);
      rd_chk(12'h300, 32'h00000006);
   endtask : test_enable_views

   // irq follows flag and enable together
   task test_irq();
      ahb_xfer(1'b1, 12'h300, 32'h00000002);
      pvr_far_side_model_i.fire(3'h1);
      wait_cycles(2);
      `CHK("irq other event", 1'b0, irq)
      pvr_far_side_model_i.fire(3'h2);
      wait_cycles(2);
      `CHK("irq raised", 1'b1, irq)
      ahb_xfer(1'b1, 12'h308, 32'h00000002);
      wait_cycles(2);
      `CHK("irq masked", 1'b0, irq)
      ahb_xfer(1'b1, 12'h304, 32'h00000002);
      wait_cycles(2);
      `CHK("irq unmasked", 1'b1, irq)
      ahb_xfer(1'b1, 12'h104, 32'h00000000);
      wait_cycles(2);
      `CHK("irq after flag clear", 1'b0, irq)
   endtask : test_irq

   // reset, then the scenarios in turn
   initial
   begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      wait_cycles(5);
      resetn <= 1'b1;
      wait_cycles(2);
      `CHK("ready after reset", 1'b1, hreadyout)
      test_reset_values();
      test_event_flags();
      test_publish();
      test_set_wins();
      test_enable_views();
      test_irq();
      report_and_stop();
   end
endmodule : pvr_violation_event_regs_test
`default_nettype wire
